// [rtl/msc_sideband.sv]
/*
 * Sideband pin logic of a pluggable module: select gating of the management bus,
 * filtered hardware reset, reset-completion interrupt, low-power request and presence.
 * Assumes the two-wire engine sits on the same clock and asks here before driving data.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - While select is low the management bus engine is enabled and may answer.
// - While select is high the engine is disabled and the data line is never driven.
// - The select pin is pulled up inside the module so it reads deselected when open.
// - A qualified reset pulse restores every user setting to its default.
// - The initialisation interval starts when the reset pin rises again.
// - At the end of initialisation the interrupt is pulled low and not-ready clears.
// - After power-up the same completion interrupt is raised with no reset pulse.
// - While low-power is requested the module runs in its reduced power level below 3 W.
// - The presence indicator is held low while the module is seated.
// - The interrupt output only ever pulls low; the host supplies the pull-up.
// - A reset request needs the reset pin low for at least 2 us.
// - The module is fully functional within 2000 ms of the reset rising edge.
// - Not-ready sits at bit 0 of status byte 2 and clears together with the interrupt.
// - The interrupt is released within 500 us of a clearing read of its flag.
module msc_sideband
	import msc_pkg::*;
#(
	parameter int unsigned P_INIT_CYC = MSC_INIT_CYC
) (
	input  wire logic                    i_clk,
	input  wire logic                    i_reset_n,
	input  wire logic                    i_ce,
	input  wire logic                    i_module_select_n_pin,
	input  wire logic                    i_module_reset_n,
	input  wire logic                    i_low_power_request,
	input  wire logic                    i_sda_drive_req,
	input  wire logic                    i_mgmt_read_strobe,
	input  wire logic [7:0]              i_mgmt_read_addr,
	output logic                         o_mgmt_enable,
	output logic                         o_sda_out,
	output logic                         o_sda_oe,
	output logic                         o_module_select_pullup_en,
	output logic                         o_reset_input_pullup_pin_en,
	output logic                         o_defaults_restore,
	output logic                         o_not_ready,
	output logic [MSC_STATUS_W-1:0]      o_status_byte2,
	output logic                         o_interrupt_request_n_out,
	output logic                         o_interrupt_request_n_oe,
	output logic                         o_low_power_mode,
	output logic                         o_presence_indicator_n_out,
	output logic                         o_presence_indicator_n_oe
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic select_n_sync;
	logic reset_n_sync;
	logic lowpwr_sync;

	msc_sync2 #(.P_RST(MSC_SELECT_N_RST)) u_sync_select (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_async   (i_module_select_n_pin),
		.o_sync    (select_n_sync)
	);
	msc_sync2 #(.P_RST(MSC_RESET_PIN_RST)) u_sync_reset (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_async   (i_module_reset_n),
		.o_sync    (reset_n_sync)
	);
	msc_sync2 #(.P_RST(MSC_LOWPWR_RST)) u_sync_lowpwr (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_async   (i_low_power_request),
		.o_sync    (lowpwr_sync)
	);

	// ************************************************************
	// Reset filter and initialisation sequence
	// ************************************************************
	localparam logic [MSC_RST_CNT_W-1:0]  RST_LAST  = MSC_RST_CNT_W'(MSC_RESET_MIN_CYC - 1);
	localparam logic [MSC_INIT_CNT_W-1:0] INIT_LAST = MSC_INIT_CNT_W'(P_INIT_CYC - 1);

	msc_state_t                state_r;
	msc_state_t                state_nxt;
	logic [MSC_RST_CNT_W-1:0]  rst_cnt_r;
	logic [MSC_RST_CNT_W-1:0]  rst_cnt_nxt;
	logic [MSC_INIT_CNT_W-1:0] init_cnt_r;
	logic [MSC_INIT_CNT_W-1:0] init_cnt_nxt;
	logic                      irq_r;
	logic                      irq_nxt;
	logic                      irq_set;
	logic                      irq_clear;

	// Interrupt release is immediate, well inside the allowed release window.
	assign irq_clear = i_mgmt_read_strobe && (i_mgmt_read_addr == MSC_STATUS_BYTE_ADDR);

	always_comb begin
		state_nxt    = state_r;
		rst_cnt_nxt  = rst_cnt_r;
		init_cnt_nxt = init_cnt_r;
		irq_set      = 1'b0;
		// Low samples are counted; a release before the count is up discards the pulse.
		if (reset_n_sync) begin
			rst_cnt_nxt = '0;
		end else if (rst_cnt_r != RST_LAST) begin
			rst_cnt_nxt = rst_cnt_r + 1'b1;
		end
		unique case (state_r)
			MSC_ST_HELD: begin
				if (reset_n_sync) begin
					state_nxt    = MSC_ST_INIT;
					init_cnt_nxt = '0;
				end
			end
			MSC_ST_INIT: begin
				if (init_cnt_r == INIT_LAST) begin
					state_nxt = MSC_ST_READY;
					irq_set   = 1'b1;
				end else begin
					init_cnt_nxt = init_cnt_r + 1'b1;
				end
			end
			MSC_ST_READY: begin
			end
		endcase
		if (!reset_n_sync && rst_cnt_r == RST_LAST) begin
			state_nxt = MSC_ST_HELD;
			irq_set   = 1'b0;
		end
		// A set in the same cycle as a clearing read wins.
		if (state_nxt == MSC_ST_HELD) begin
			irq_nxt = 1'b0;
		end else begin
			irq_nxt = irq_set || (irq_r && !irq_clear);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			// Power-up goes straight into initialisation without a reset pulse.
			state_r    <= MSC_ST_INIT;
			rst_cnt_r  <= '0;
			init_cnt_r <= '0;
			irq_r      <= 1'b0;
		end else if (i_ce) begin
			state_r    <= state_nxt;
			rst_cnt_r  <= rst_cnt_nxt;
			init_cnt_r <= init_cnt_nxt;
			irq_r      <= irq_nxt;
		end
	end

	// ************************************************************
	// Output registers
	// ************************************************************
	logic mgmt_en_nxt;
	logic sda_oe_nxt;
	logic not_ready_nxt;

	always_comb begin
		mgmt_en_nxt   = !select_n_sync;
		sda_oe_nxt    = !select_n_sync && i_sda_drive_req;
		not_ready_nxt = (state_nxt != MSC_ST_READY);
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_mgmt_enable               <= 1'b0;
			o_sda_out                   <= 1'b0;
			o_sda_oe                    <= 1'b0;
			o_module_select_pullup_en   <= 1'b1;
			o_reset_input_pullup_pin_en <= 1'b1;
			o_defaults_restore          <= 1'b0;
			o_not_ready                 <= 1'b1;
			o_status_byte2              <= MSC_STATUS_W'(1) << MSC_NOT_READY_BIT;
			o_interrupt_request_n_out   <= 1'b0;
			o_interrupt_request_n_oe    <= 1'b0;
			o_low_power_mode            <= 1'b0;
			o_presence_indicator_n_out  <= 1'b0;
			o_presence_indicator_n_oe   <= 1'b1;
		end else if (i_ce) begin
			o_mgmt_enable               <= mgmt_en_nxt;
			o_sda_oe                    <= sda_oe_nxt;
			o_defaults_restore          <= (state_nxt == MSC_ST_HELD);
			o_not_ready                 <= not_ready_nxt;
			o_status_byte2              <= MSC_STATUS_W'(not_ready_nxt) << MSC_NOT_READY_BIT;
			o_interrupt_request_n_oe    <= irq_nxt;
			o_low_power_mode            <= lowpwr_sync;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	sda_gate_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_sda_oe |-> o_mgmt_enable && !o_sda_out)
		else $error("data line driven while deselected");

	mgmt_follow_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$past(i_ce) |-> o_mgmt_enable == !$past(select_n_sync))
		else $error("bus enable does not follow select");

	reset_filter_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_r == MSC_ST_HELD && $past(state_r) != MSC_ST_HELD |-> $past(rst_cnt_r) == RST_LAST)
		else $error("reset taken before minimum pulse length");

	defaults_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_defaults_restore == (state_r == MSC_ST_HELD))
		else $error("defaults restore does not track reset state");

	init_start_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$past(state_r) == MSC_ST_HELD && state_r == MSC_ST_INIT |-> $past(reset_n_sync) && init_cnt_r == '0)
		else $error("init started without reset release");

	ready_irq_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_r == MSC_ST_READY && $past(state_r) == MSC_ST_INIT |-> o_interrupt_request_n_oe && !o_not_ready)
		else $error("completion interrupt missing");

	powerup_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(i_reset_n) |-> state_r == MSC_ST_INIT && o_not_ready)
		else $error("power-up did not enter initialisation");

	lowpwr_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$past(i_ce) |-> o_low_power_mode == $past(lowpwr_sync))
		else $error("low power mode does not follow request");

	irq_release_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$past(i_ce) && $past(irq_clear) && !$past(irq_set) |-> !o_interrupt_request_n_oe)
		else $error("interrupt not released after clearing read");

	not_ready_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_status_byte2 == (MSC_STATUS_W'(o_not_ready) << MSC_NOT_READY_BIT)
		&& !(o_interrupt_request_n_oe && o_not_ready))
		else $error("not-ready bit inconsistent with interrupt");

	presence_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_presence_indicator_n_oe && !o_presence_indicator_n_out && !o_interrupt_request_n_out)
		else $error("presence or interrupt pin level wrong");

	reset_held_c: cover property (@(posedge i_clk) disable iff (!i_reset_n)
		state_r == MSC_ST_HELD ##[1:20] state_r == MSC_ST_INIT);
	ready_c: cover property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(o_interrupt_request_n_oe));
	release_c: cover property (@(posedge i_clk) disable iff (!i_reset_n)
		$fell(o_interrupt_request_n_oe) && state_r == MSC_ST_READY);

endmodule

// [rtl/msc_pkg.sv]
/*
 * Constants and types shared by the module sideband control logic.
 * Assumes a single 125 MHz core clock; all times are turned into cycle counts here.
 */
package msc_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int unsigned MSC_CLK_PERIOD_NS = 8;
	localparam int unsigned MSC_RESET_MIN_US  = 2;
	// A least time, so it rounds up.
	localparam int unsigned MSC_RESET_MIN_CYC =
		(MSC_RESET_MIN_US * 1000 + MSC_CLK_PERIOD_NS - 1) / MSC_CLK_PERIOD_NS;
	localparam int unsigned MSC_INIT_TIME_MS  = 2000;
	// A longest time, so it rounds down.
	localparam int unsigned MSC_INIT_CYC      = (MSC_INIT_TIME_MS * 1000000) / MSC_CLK_PERIOD_NS;
	localparam int unsigned MSC_RST_CNT_W     = 8;
	localparam int unsigned MSC_INIT_CNT_W    = 28;

	// ************************************************************
	// Status byte layout
	// ************************************************************
	localparam logic [7:0]  MSC_STATUS_BYTE_ADDR = 8'h02;
	localparam int unsigned MSC_NOT_READY_BIT    = 0;
	localparam int unsigned MSC_STATUS_W         = 8;

	// ************************************************************
	// Reset values of the pin synchronisers
	// ************************************************************
	localparam logic MSC_SELECT_N_RST  = 1'b1;
	localparam logic MSC_RESET_PIN_RST = 1'b1;
	localparam logic MSC_LOWPWR_RST    = 1'b0;

	typedef enum logic [1:0] {
		MSC_ST_HELD,
		MSC_ST_INIT,
		MSC_ST_READY
	} msc_state_t;

endpackage

// [rtl/msc_sync2.sv]
/*
 * Two flip-flop level synchroniser for one asynchronous pin.
 * Assumes the pin level is quasi-static compared with the clock period.
 */
`timescale 1ns/1ps
module msc_sync2 #(
	parameter logic P_RST = 1'b0
) (
	input  wire logic i_clk,
	input  wire logic i_reset_n,
	input  wire logic i_ce,
	input  wire logic i_async,
	output logic      o_sync
);

	logic meta_r;
	logic sync_r;

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			meta_r <= P_RST;
			sync_r <= P_RST;
		end else if (i_ce) begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;

endmodule

// [verif/msc_host_model.sv]
/*
 * Host board side of the sideband pins: select driver and board pull-ups.
 * Assumes the host drives select by level and relies on pull-ups for open lines.
 */
`timescale 1ns/1ps
module msc_host_model (
	input  wire logic i_sel_drive_en,
	input  wire logic i_sel_drive_val,
	input  wire logic i_sel_pullup_en,
	input  wire logic i_irq_oe,
	input  wire logic i_irq_out,
	input  wire logic i_pres_oe,
	input  wire logic i_pres_out,
	output logic      o_sel_level,
	output logic      o_irq_line,
	output logic      o_pres_line
);
	// ************************************************************
	// Wire resolution
	// ************************************************************
	// A select pin left open without its pull-up floats; reading it low makes that loss look like selection.
	assign o_sel_level = i_sel_drive_en ? i_sel_drive_val : i_sel_pullup_en;
	assign o_irq_line  = i_irq_oe ? i_irq_out : 1'b1;
	assign o_pres_line = i_pres_oe ? i_pres_out : 1'b1;
endmodule

// [verif/msc_sideband_tb_top.sv]
/*
 * Self-checking bench for the sideband pin logic with a short initialisation count.
 * Assumes the host model resolves the select, interrupt and presence pins; the clock enable drops only in the last scenario.
 */
`timescale 1ns/1ps
module msc_sideband_tb_top;
	import msc_pkg::*;
	localparam int unsigned P_INIT = 100;
	typedef struct {int unsigned sel; logic [7:0] val;} msc_note_t;
	msc_note_t   q[$];
	msc_note_t   n;
	int unsigned failures = 0;
	int unsigned cmp_count = 0;
	int unsigned cyc = 0;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        ce = 1'b1;
	logic        sel_en = 1'b1;
	logic        sel_val = 1'b1;
	logic        mrst_n = 1'b1;
	logic        lp = 1'b0;
	logic        req = 1'b0;
	logic        strb = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic        sel_lvl, irq_lvl, pres_lvl, en, sda_o, sda_oe, sel_pu, rst_pu, defl, nrdy, irq_o, irq_oe, lpm;
	logic        pr_o, pr_oe;
	logic [7:0]  stat;

	always #4 clk = ~clk;

	msc_sideband #(.P_INIT_CYC(P_INIT)) i_dut (.i_clk(clk), .i_reset_n(reset_n), .i_ce(ce),
		.i_module_select_n_pin(sel_lvl), .i_module_reset_n(mrst_n), .i_low_power_request(lp),
		.i_sda_drive_req(req), .i_mgmt_read_strobe(strb), .i_mgmt_read_addr(addr), .o_mgmt_enable(en),
		.o_sda_out(sda_o), .o_sda_oe(sda_oe), .o_module_select_pullup_en(sel_pu),
		.o_reset_input_pullup_pin_en(rst_pu), .o_defaults_restore(defl), .o_not_ready(nrdy),
		.o_status_byte2(stat), .o_interrupt_request_n_out(irq_o), .o_interrupt_request_n_oe(irq_oe),
		.o_low_power_mode(lpm), .o_presence_indicator_n_out(pr_o), .o_presence_indicator_n_oe(pr_oe));

	msc_host_model i_host (.i_sel_drive_en(sel_en), .i_sel_drive_val(sel_val), .i_sel_pullup_en(sel_pu),
		.i_irq_oe(irq_oe), .i_irq_out(irq_o), .i_pres_oe(pr_oe), .i_pres_out(pr_o),
		.o_sel_level(sel_lvl), .o_irq_line(irq_lvl), .o_pres_line(pres_lvl));

	function automatic logic [7:0] obs(input int unsigned s);
		case (s)
			0: obs = {7'h00, en};
			1: obs = {7'h00, sda_oe};
			2: obs = {7'h00, defl};
			3: obs = {7'h00, nrdy};
			4: obs = {7'h00, irq_lvl};
			5: obs = {7'h00, lpm};
			6: obs = stat;
			default: obs = {3'h0, sda_o, irq_o, pres_lvl, sel_pu, rst_pu};
		endcase
	endfunction

	task automatic complete_run();
		if (failures == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// The note is taken one edge on, so it judges the outputs after that edge has landed.
	task automatic chk(input int unsigned s, input logic [7:0] v);
		@(posedge clk);
		q.push_back('{s, v});
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		strb <= 1'b1;
		addr <= a;
		@(posedge clk);
		strb <= 1'b0;
	endtask

	task automatic wait_init();
		repeat (P_INIT - 12) @(posedge clk);
		chk(4, 8'h01);
		chk(3, 8'h01);
		repeat (16) @(posedge clk);
		chk(4, 8'h00);
		chk(3, 8'h00);
		chk(6, 8'h00);
	endtask

	always @(negedge clk) begin
		while (q.size() != 0) begin
			n = q.pop_front();
			cmp_count++;
			if (obs(n.sel) !== n.val) begin
				failures++;
				$display("BAD t=%0t got=%h exp=%h", $time, obs(n.sel), n.val);
			end
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			complete_run();
		end
	end

	initial begin
		void'($urandom(36763));
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		chk(3, 8'h01);
		chk(7, 8'h03);
		wait_init();
		rd(8'h03);
		chk(4, 8'h00);
		rd(8'h02);
		chk(4, 8'h01);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			// Only this module's select is ever pulled low; an open pin must read deselected.
			sel_en <= 1'($urandom);
			sel_val <= 1'($urandom);
			req <= 1'($urandom);
			lp <= 1'($urandom);
			repeat (4) @(posedge clk);
			chk(0, {7'h00, sel_en & ~sel_val});
			chk(1, {7'h00, sel_en & ~sel_val & req});
			chk(5, {7'h00, lp});
		end
		@(posedge clk);
		mrst_n <= 1'b0;
		repeat (240) @(posedge clk);
		mrst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk(2, 8'h00);
		chk(3, 8'h00);
		@(posedge clk);
		mrst_n <= 1'b0;
		repeat (262) @(posedge clk);
		chk(2, 8'h01);
		chk(3, 8'h01);
		chk(6, 8'h01);
		repeat (20) @(posedge clk);
		mrst_n <= 1'b1;
		repeat (5) @(posedge clk);
		chk(2, 8'h00);
		wait_init();
		// A low clock enable must hold the low-power output although the pin moves.
		@(posedge clk);
		ce <= 1'b0;
		lp <= ~lp;
		repeat (6) @(posedge clk);
		chk(5, {7'h00, ~lp});
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		chk(5, {7'h00, lp});
		repeat (2) @(posedge clk);
		complete_run();
	end
endmodule
